//--- verilog/cbl_map.svh
// cbl_map.svh: constants for the bus lane and clock interface block
// assumes: included by bare name from the package and the bus interface module
`ifndef CBL_MAP_SVH
`define CBL_MAP_SVH
`define CBL_LANES      4
`define CBL_DATA_W     32
`define CBL_HALF_W     16
`define CBL_LANE_NONE  4'hf
`define CBL_OP_WAIT    2'h1
`define CBL_OP_STACK   2'h2
`define CBL_OP_NOWAIT  2'h3
`endif

//--- verilog/cbl_pkg.sv
// cbl_pkg.sv: types shared by the bus lane and clock interface block
// assumes: cbl_map.svh is on the include path
`default_nettype none
`include "cbl_map.svh"
package cbl_pkg;
  typedef enum logic [3:0] {
    CBL_IDLE  = 4'b0001,
    CBL_LOW   = 4'b0010,
    CBL_HIGH  = 4'b0100,
    CBL_DONE  = 4'b1000
  } cbl_bus_e;
  typedef enum logic [2:0] {
    CBL_C_IDLE = 3'b001,
    CBL_C_WAIT = 3'b010,
    CBL_C_GO   = 3'b100
  } cbl_cop_e;
endpackage
`default_nettype wire

//--- verilog/cbl_sync.sv
// cbl_sync.sv: two-flop synchroniser for pin inputs
// assumes: single clock domain, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module cbl_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic meta;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // cbl_sync
`default_nettype wire

//--- verilog/cbl_bus_if.sv
// cbl_bus_if.sv: byte-lane, half-width split, coprocessor busy gate and clock phase
// assumes: ref_clk is the double-rate clock input; pins half_width_bus_n and copro_busy_n are asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "cbl_map.svh"
module cbl_bus_if
  import cbl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [3:0]  req_lanes,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             cycle_start,
  output logic             lane3_enable_n,
  output logic             lane2_enable_n,
  output logic             lane1_enable_n,
  output logic             lane0_enable_n,
  output logic             lane_oe,
  output logic [31:0]      data_out,
  output logic             data_oe,
  input  wire logic [31:0] data_in,
  input  wire logic        cycle_done,
  input  wire logic        half_width_bus_n,
  input  wire logic        copro_busy_n,
  input  wire logic        cop_valid,
  input  wire logic [1:0]  cop_op,
  output logic             cop_issue,
  output logic             core_clk_phase,
  output logic             bus_clk_phase
);
  logic        half_s;
  logic        busy_s;
  cbl_bus_e    bstate;
  cbl_cop_e    cstate;
  logic        wr;
  logic [3:0]  lanes;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        half_lat;
  logic        both_halves;
  logic [3:0]  next_lanes_n;

  cbl_sync u_half (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(half_width_bus_n), .dout(half_s));
  cbl_sync u_busy (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(copro_busy_n), .dout(busy_s));

  // clock phase restarts at reset release so phase 0 follows it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_clk_phase <= 1'b0;
      bus_clk_phase  <= 1'b0;
    end else begin
      core_clk_phase <= ~core_clk_phase;
      bus_clk_phase  <= ~core_clk_phase;
    end
  end

  assign both_halves = (|lanes[1:0]) && (|lanes[3:2]);
  always_comb begin
    next_lanes_n = ~lanes;
  end

  // bus cycle sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bstate         <= CBL_IDLE;
      wr             <= 1'b0;
      lanes          <= 4'h0;
      wdata          <= 32'h0;
      rdata          <= 32'h0;
      half_lat       <= 1'b0;
      req_ready      <= 1'b1;
      rsp_valid      <= 1'b0;
      rsp_rdata      <= 32'h0;
      cycle_start    <= 1'b0;
      {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n} <= `CBL_LANE_NONE;
      lane_oe        <= 1'b0;
      data_out       <= 32'h0;
      data_oe        <= 1'b0;
    end else begin
      rsp_valid   <= 1'b0;
      cycle_start <= 1'b0;
      case (bstate)
        CBL_IDLE: begin
          if (req_valid && req_ready && (req_lanes != 4'h0)) begin
            wr        <= req_write;
            lanes     <= req_lanes;
            wdata     <= req_wdata;
            rdata     <= 32'h0;
            req_ready <= 1'b0;
            bstate    <= CBL_LOW;
          end
        end
        CBL_LOW: begin
          // first cycle: all enabled lanes, upper bytes mirrored low on writes that enable no lower lane
          {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n} <= next_lanes_n;
          lane_oe     <= 1'b1;
          data_oe     <= wr;
          data_out    <= {wdata[31:16],
                          (|lanes[1:0]) ? wdata[15:0] : wdata[31:16]};
          cycle_start <= 1'b1;
          bstate      <= CBL_DONE;
          half_lat    <= 1'b0;
        end
        CBL_HIGH: begin
          // second half-width cycle carries the upper half on the lower lines
          {lane3_enable_n, lane2_enable_n} <= ~lanes[3:2];
          {lane1_enable_n, lane0_enable_n} <= 2'h3;
          data_out    <= {wdata[31:16], wdata[31:16]};
          cycle_start <= 1'b1;
          half_lat    <= 1'b1;
          bstate      <= CBL_DONE;
        end
        CBL_DONE: begin
          if (cycle_done) begin
            if (!half_s) begin
              // half-width cycle: only the lower sixteen lines are captured
              if (half_lat)
                rdata[31:16] <= data_in[15:0];
              else begin
                rdata[15:0]  <= data_in[15:0];
                if (!(|lanes[1:0]))
                  rdata[31:16] <= data_in[15:0];
              end
            end else
              rdata <= data_in;
            if (!half_s && !half_lat && both_halves) begin
              bstate <= CBL_HIGH;
            end else begin
              rsp_valid <= 1'b1;
              rsp_rdata <= (!half_s) ? (half_lat ? {data_in[15:0], rdata[15:0]}
                                       : ((|lanes[1:0]) ? {rdata[31:16], data_in[15:0]}
                                                        : {data_in[15:0], rdata[15:0]}))
                                     : data_in;
              {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n} <= `CBL_LANE_NONE;
              lane_oe   <= 1'b0;
              data_oe   <= 1'b0;
              req_ready <= 1'b1;
              bstate    <= CBL_IDLE;
            end
          end
        end
        default: bstate <= CBL_IDLE;
      endcase
    end
  end

  // coprocessor issue gate
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cstate    <= CBL_C_IDLE;
      cop_issue <= 1'b0;
    end else begin
      cop_issue <= 1'b0;
      case (cstate)
        CBL_C_IDLE: begin
          if (cop_valid) begin
            if (cop_op == `CBL_OP_NOWAIT)
              cstate <= CBL_C_GO;
            else if (cop_op == `CBL_OP_WAIT || cop_op == `CBL_OP_STACK)
              cstate <= CBL_C_WAIT;
            else
              cstate <= CBL_C_GO;
          end
        end
        CBL_C_WAIT: begin
          if (busy_s)
            cstate <= CBL_C_GO;
        end
        CBL_C_GO: begin
          cop_issue <= 1'b1;
          cstate    <= CBL_C_IDLE;
        end
        default: cstate <= CBL_C_IDLE;
      endcase
    end
  end

  // sequencer, issue gate and clock phase checks
  chk_issue_not_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cstate == CBL_C_WAIT && !busy_s) |=> !cop_issue) else $error("issue while busy");
  chk_wait_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cstate == CBL_C_WAIT && !busy_s) |=> cstate == CBL_C_WAIT)
    else $error("left wait while busy");
  chk_nowait_fast: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cstate == CBL_C_IDLE && cop_valid && cop_op == `CBL_OP_NOWAIT) |-> ##2 cop_issue)
    else $error("nowait op delayed");
  chk_nowait_skip: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cstate == CBL_C_IDLE && cop_valid && cop_op == `CBL_OP_NOWAIT) |=> cstate == CBL_C_GO)
    else $error("nowait op waited");
  chk_wait_samples: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cstate == CBL_C_IDLE && cop_valid && cop_op == `CBL_OP_STACK) |=> cstate == CBL_C_WAIT)
    else $error("busy not sampled");
  chk_wait_op: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cstate == CBL_C_IDLE && cop_valid && cop_op == `CBL_OP_WAIT) |=> cstate == CBL_C_WAIT)
    else $error("wait op not gated");
  chk_clock_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> core_clk_phase != $past(core_clk_phase)) else $error("clock not divided");
  chk_phase_align: assert property (@(posedge ref_clk)
    $fell(sys_rst) |-> !core_clk_phase) else $error("phase not aligned");
  chk_bus_clk: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> bus_clk_phase != $past(bus_clk_phase)) else $error("bus clock wrong");
  chk_lanes_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !lane_oe |-> {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n} == `CBL_LANE_NONE)
    else $error("lanes active idle");
  chk_lanes_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (lane_oe && bstate == CBL_DONE && !cycle_done) |=>
    $stable({lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n})) else $error("lanes moved");
  chk_split_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bstate == CBL_DONE && cycle_done && !half_s && !half_lat && both_halves) |=> ##1
    (cycle_start && lane0_enable_n && lane1_enable_n)) else $error("no upper cycle");
  chk_split_ends: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bstate == CBL_DONE && cycle_done && half_lat) |=> rsp_valid) else $error("split not ended");
  chk_mirror: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cycle_start && data_oe && lane0_enable_n && lane1_enable_n) |-> data_out[15:0] == data_out[31:16])
    else $error("upper not mirrored");
  chk_ready_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bstate != CBL_IDLE) |-> !req_ready) else $error("ready during access");
endmodule // cbl_bus_if
`default_nettype wire

//--- test/cbl_far_end.sv
// cbl_far_end.sv: bus controller, memory and coprocessor beside cbl_bus_if
// assumes: bench sets rd_word, wait_cyc and half before each access
`timescale 1ns/1ns
`default_nettype none
module cbl_far_end (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        cycle_start,
  input  wire logic [3:0]  lanes_n,
  input  wire logic [31:0] rd_word,
  input  wire logic [1:0]  wait_cyc,
  input  wire logic        half,
  input  wire logic        cop_issue,
  output logic             cycle_done,
  output logic [31:0]      data_in,
  output logic             half_width_bus_n,
  output logic             copro_busy_n,
  output logic [1:0]       low_address_bits
);
  logic [1:0] cnt;
  logic       on;
  logic [3:0] bcnt;
  assign half_width_bus_n = !half;
  assign copro_busy_n = (bcnt == 4'h0);
  // low address rebuilt from the enables: index of the lowest enabled lane
  assign low_address_bits = {lanes_n[0] & lanes_n[1], lanes_n[0] & (lanes_n[2] | ~lanes_n[1])};
  always_ff @(posedge ref_clk) begin
    cycle_done <= 1'b0;
    // released lines never keep the last word
    data_in <= ~data_in;
    if (sys_rst) begin
      on <= 1'b0;
      data_in <= 32'h0;
    end else if (cycle_start) begin
      on <= 1'b1;
      cnt <= wait_cyc;
    end else if (on && cnt == 2'h0) begin
      on <= 1'b0;
      cycle_done <= 1'b1;
      // 16-bit slave answers the upper half on the low lines
      data_in <= (half && low_address_bits[1]) ? {2{rd_word[31:16]}} : rd_word;
    end else if (on) begin
      cnt <= cnt - 2'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) bcnt <= 4'h0;
    else if (cop_issue) bcnt <= 4'hc;
    else if (bcnt != 4'h0) bcnt <= bcnt - 4'h1;
  end
endmodule // cbl_far_end
`default_nettype wire

//--- test/cbl_bus_if_tb.sv
// cbl_bus_if_tb.sv: self-checking bench for cbl_bus_if
// assumes: cbl_far_end models everything across the bus pins
`timescale 1ns/1ns
`default_nettype none
module cbl_bus_if_tb;
  logic        ref_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, cop_valid = 0, half = 0, pb;
  logic [3:0]  req_lanes = 0;
  logic [31:0] req_wdata = 0, rd_word = 0, data_in, rsp_rdata, data_out, mm;
  logic [1:0]  cop_op = 0, wait_cyc = 0;
  logic        req_ready, rsp_valid, cycle_start, lane_oe, data_oe, cycle_done, cop_issue;
  logic        lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n;
  logic        half_width_bus_n, copro_busy_n, core_clk_phase, bus_clk_phase;
  logic [1:0]  low_address_bits;
  logic [63:0] qe[$], qr[$];
  logic [31:0] qm[$], qrm[$];
  logic        qg[$];
  int          n_fail = 0, checks_done = 0, k = 0, hi = 0, cyc = 0;
  cbl_bus_if DUT (.ref_clk, .sys_rst, .req_valid, .req_write, .req_lanes, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .cycle_start, .lane3_enable_n, .lane2_enable_n, .lane1_enable_n,
    .lane0_enable_n, .lane_oe, .data_out, .data_oe, .data_in, .cycle_done, .half_width_bus_n,
    .copro_busy_n, .cop_valid, .cop_op, .cop_issue, .core_clk_phase, .bus_clk_phase);
  cbl_far_end far (.ref_clk, .sys_rst, .cycle_start, .rd_word, .wait_cyc, .half, .cop_issue,
    .lanes_n({lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n}),
    .cycle_done, .data_in, .half_width_bus_n, .copro_busy_n, .low_address_bits);
  initial forever #4 ref_clk = ~ref_clk;
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_bus(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp_bus({63'h0, g}, {63'h0, e});
  endtask
  function automatic logic [31:0] bm(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  function automatic logic [1:0] lo(input logic [3:0] l);
    lo = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (l[i]) lo = 2'(i);
  endfunction
  task automatic acc(input logic wr, input logic [3:0] l);
    logic [31:0] w, r, m, d, cm;
    logic        two;
    w = $urandom;
    r = $urandom;
    two = half && l[3:2] != 2'h0 && l[1:0] != 2'h0;
    m = bm(l);
    if (l[1:0] == 2'h0) m[15:0] = m[31:16];
    if (two) m[31:16] = 16'h0;
    d = (l[1:0] == 2'h0) ? {2{w[31:16]}} : w;
    cm = wr ? m : 32'h0;
    qe.push_back({24'h0, lo(l), 1'b1, wr, ~l, d & cm});
    qm.push_back(cm);
    if (two) begin
      cm = wr ? bm({2'h0, l[3:2]}) : 32'h0;
      qe.push_back({24'h0, lo({l[3:2], 2'h0}), 1'b1, wr, ~l | 4'h3, {2{w[31:16]}} & cm});
      qm.push_back(cm);
    end
    cm = wr ? 32'h0 : bm(l);
    qr.push_back({32'h0, r & cm});
    qrm.push_back(cm);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_lanes <= l;
    req_wdata <= w;
    rd_word <= r;
    wait_cyc <= 2'($urandom_range(3, 0));
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
  endtask
  task automatic cop(input logic [1:0] op);
    int n;
    n = 0;
    qg.push_back(op == 2'h1 || op == 2'h2);
    @(posedge ref_clk);
    cop_valid <= 1'b1;
    cop_op <= op;
    @(posedge ref_clk);
    cop_valid <= 1'b0;
    do begin @(posedge ref_clk); n++; end while (cop_issue !== 1'b1 && n < 40);
    cmp_flag((op == 2'h1 || op == 2'h2) ? (n < 40) : (n == 2), 1'b1);
  endtask
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      k = 0;
      hi = 0;
    end else begin
      cmp_flag(core_clk_phase, k[0]);
      if (k > 1) cmp_flag(bus_clk_phase, !pb);
      if (cycle_done) begin
        mm = qm.pop_front();
        cmp_bus({24'h0, low_address_bits, lane_oe, data_oe, lane3_enable_n, lane2_enable_n, lane1_enable_n,
          lane0_enable_n, data_out & mm}, qe.pop_front());
      end
      if (rsp_valid) begin
        mm = qrm.pop_front();
        cmp_bus({32'h0, rsp_rdata & mm}, qr.pop_front());
      end
      if (cop_issue && qg.pop_front()) cmp_flag(hi >= 2, 1'b1);
      k++;
      pb = bus_clk_phase;
      hi = copro_busy_n ? hi + 1 : 0;
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h6c768300));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int h = 0; h < 2; h++) begin
      half <= h[0];
      repeat (4) @(posedge ref_clk);
      for (int l = 1; l < 16; l++) begin
        acc(1'b1, l[3:0]);
        acc(1'b0, l[3:0]);
      end
    end
    cop(2'h0);
    cop(2'h3);
    cop(2'h1);
    cop(2'h2);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc(1'b1, 4'hf);
    repeat (8) @(posedge ref_clk);
    cmp_flag(qe.size() == 0 && qr.size() == 0 && qg.size() == 0, 1'b1);
    report_and_stop();
  end
endmodule // cbl_bus_if_tb
`default_nettype wire
